// file: dv/twm_properties.sv
`timescale 1ns/1ps
// Watches the register port and the open-drain pins of the controller.
module twm_properties (
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        scl_i,
   input wire logic        scl_o,
   input wire logic        scl_oe,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe,
   input wire logic        irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // Data changes while the clock line is free are the bus conditions.
   sequence start_edge;
      $rose(sda_oe) && !scl_oe;
   endsequence
   sequence stop_edge;
      $fell(sda_oe) && !scl_oe;
   endsequence
   ready_one_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
   ready_drop_a: assert property (pready |=> !pready) else $error("ready held too long");
   err_map_a: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08})) else $error("bad slverr");
   upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("read upper bits set");
   open_drain_a: assert property (!scl_o && !sda_o) else $error("pin driven high");
   start_low_a: assert property (start_edge |-> ##[1:600] scl_oe) else $error("clock not held after start");
   stop_idle_a: assert property (stop_edge |-> (!sda_oe && !scl_oe) [*4]) else $error("lines busy after stop");
   hold_still_a: assert property (irq && $past(irq) && !$past(psel) |-> $stable(sda_oe) && $stable(scl_oe))
      else $error("bus moved while suspended");
endmodule // twm_properties

bind twm_top twm_properties u_props (.mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i),
   .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));

// file: dv/twm_slave.sv
`timescale 1ns/1ps
// Behavioural slave receiver: counts bus conditions, collects bytes and acknowledges them.
module twm_slave (
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic nack,
   output logic      pull,
   output logic [7:0] last,
   output int        nstart,
   output int        nstop
);
   int         bitn = 0;
   logic [7:0] sh = 8'h00;
   initial begin
      pull = 1'b0;
      last = 8'h00;
      nstart = 0;
      nstop = 0;
   end
   // A falling data line under a free clock is a start.
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         nstart++;
         bitn = 0;
      end
   end
   // The time guard skips the power-up edge, which is no stop.
   always @(posedge sda) begin
      if (scl === 1'b1 && $time > 0) begin
         nstop++;
         bitn = 0;
      end
   end
   // Bits are taken on the rising clock, most significant first.
   always @(posedge scl) begin
      if (bitn < 8) begin
         sh = {sh[6:0], sda};
      end
      bitn++;
   end
   // Acknowledge is held from the fall after bit eight until the fall after bit nine.
   always @(negedge scl) begin
      if (bitn == 8) begin
         pull = !nack;
         last = sh;
      end else if (bitn == 9) begin
         pull = 1'b0;
         bitn = 0;
      end
   end
endmodule // twm_slave

// file: dv/twm_top_test.sv
`timescale 1ns/1ps
// Software-side flow for a write transfer, judged against the slave model.
module twm_top_test;
   logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, irq, nack, pull;
   logic        scl_o, scl_oe, sda_o, sda_oe, scl, sda;
   logic [7:0]  paddr, last;
   logic [31:0] pwdata, prdata;
   int          nstart, nstop;
   int          failures = 0;
   int          compares = 0;
   int          cyc = 0;
   // Open-drain lines with pull-ups.
   assign scl = !scl_oe;
   assign sda = !(sda_oe || pull);
   twm_top DUT (.mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
   twm_slave u_slave (.scl(scl), .sda(sda), .nack(nack), .pull(pull), .last(last), .nstart(nstart), .nstop(nstop));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic complete_run;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // A hung wait ends the run here.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         complete_run;
      end
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One transfer; the request stands until pready is seen high at a rising edge, where the answer is taken.
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata[7:0];
      chk({7'h0, pslverr}, {7'h0, !(a inside {8'h00, 8'h04, 8'h08})});
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge keeps the next setup out of this time step.
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      apb(1'b1, a, d, r);
   endtask
   // Writes the control word, waits for the next suspension and checks its masked code.
   task automatic go(input logic [7:0] c, input logic [7:0] st);
      logic [7:0] r;
      int n;
      wr(twm_pkg::CTRL_OFS, c);
      // The old request still stands for a cycle after the clear, so see it fall before waiting for the next.
      for (n = 0; n < 5000 && irq !== 1'b0; n++) @(negedge mclk);
      for (n = 0; n < 5000 && irq !== 1'b1; n++) @(negedge mclk);
      @(posedge mclk);
      apb(1'b0, twm_pkg::STAT_OFS, 8'h00, r);
      chk(r & twm_pkg::STAT_CODE_MASK, st);
   endtask
   task automatic t_regs;
      logic [7:0] r;
      apb(1'b0, twm_pkg::CTRL_OFS, 8'h00, r);
      chk(r, twm_pkg::CTRL_RST);
      apb(1'b0, twm_pkg::STAT_OFS, 8'h00, r);
      chk(r, twm_pkg::ST_NO_INFO);
      wr(twm_pkg::STAT_OFS, 8'h01);
      apb(1'b0, twm_pkg::STAT_OFS, 8'h00, r);
      chk(r, 8'hf9);
      wr(twm_pkg::STAT_OFS, 8'h00);
      apb(1'b0, 8'h0c, 8'h00, r);
      chk(r, 8'h00);
   endtask
   task automatic t_idle;
      logic [7:0] r;
      wr(twm_pkg::CTRL_OFS, 8'ha0);
      wr(twm_pkg::DATA_OFS, 8'h5a);
      repeat (200) @(posedge mclk);
      chk(nstart[7:0], 8'h00);
      apb(1'b0, twm_pkg::CTRL_OFS, 8'h00, r);
      chk(r & 8'h08, 8'h08);
      apb(1'b0, twm_pkg::DATA_OFS, 8'h00, r);
      chk(r, twm_pkg::DATA_RST);
   endtask
   task automatic t_send;
      go(8'ha5, twm_pkg::ST_START);
      wr(twm_pkg::DATA_OFS, 8'ha4);
      go(8'h85, twm_pkg::ST_AW_ACK);
      chk(last, 8'ha4);
      wr(twm_pkg::DATA_OFS, 8'h3c);
      go(8'h85, twm_pkg::ST_D_ACK);
      chk(last, 8'h3c);
   endtask
   task automatic t_restart;
      logic [7:0] r;
      int n;
      go(8'ha5, twm_pkg::ST_REP_START);
      chk(nstop[7:0], 8'h00);
      nack <= 1'b1;
      wr(twm_pkg::DATA_OFS, 8'hb2);
      go(8'h85, twm_pkg::ST_AW_NACK);
      nack <= 1'b0;
      go(8'hb5, twm_pkg::ST_START);
      chk(nstop[7:0], 8'h01);
      wr(twm_pkg::DATA_OFS, 8'hb3);
      go(8'h85, twm_pkg::ST_AR_ACK);
      wr(twm_pkg::CTRL_OFS, 8'h95);
      for (n = 0; n < 3000 && nstop < 2; n++) @(negedge mclk);
      repeat (8) @(posedge mclk);
      apb(1'b0, twm_pkg::CTRL_OFS, 8'h00, r);
      chk(r & 8'h10, 8'h00);
      apb(1'b0, twm_pkg::STAT_OFS, 8'h00, r);
      chk(r, twm_pkg::ST_NO_INFO);
   endtask
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      nack = 1'b0;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      t_regs;
      t_idle;
      t_send;
      t_restart;
      complete_run;
   end
endmodule // twm_top_test

// file: logic/twm_pkg.sv
package twm_pkg;

   // Register byte addresses on the APB side.
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] DATA_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;

   // Reset values of the software-visible registers.
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'hff;
   localparam logic [1:0] PRESC_RST = 2'h0;

   // Status codes, prescaler bits already masked to zero.
   localparam logic [7:0] ST_START     = 8'h08;
   localparam logic [7:0] ST_REP_START = 8'h10;
   localparam logic [7:0] ST_AW_ACK    = 8'h18;
   localparam logic [7:0] ST_AW_NACK   = 8'h20;
   localparam logic [7:0] ST_D_ACK     = 8'h28;
   localparam logic [7:0] ST_D_NACK    = 8'h30;
   localparam logic [7:0] ST_ARB_LOST  = 8'h38;
   localparam logic [7:0] ST_AR_ACK    = 8'h40;
   localparam logic [7:0] ST_AR_NACK   = 8'h48;
   localparam logic [7:0] ST_NO_INFO   = 8'hf8;

   // Status field mask that software applies before comparing codes.
   localparam logic [7:0] STAT_CODE_MASK = 8'hf8;

   // Bit index of the last bit in a byte frame (eight data bits and the acknowledge).
   localparam logic [3:0] ACK_BIT_IDX = 4'h8;

   // Bus timing: one serial clock period is four quarter phases.
   localparam int CLK_PERIOD_NS = 40;
   localparam int SCL_PERIOD_NS = 320;
   localparam logic [7:0] QTR_CYCLES =
      8'((SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS));

   // Control register layout, most significant bit first.
   typedef struct packed {
      logic flag;
      logic ack_enable;
      logic start_req_bit;
      logic stop_req_bit;
      logic write_collision;
      logic enable;
      logic rsvd;
      logic irq_enable;
   } twm_ctrl_t;

   // Sequencer states.
   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_FREE  = 3'b001,
      S_START = 3'b010,
      S_XFER  = 3'b011,
      S_HOLD  = 3'b100,
      S_STOP  = 3'b101
   } twm_state_t;

endpackage

// file: logic/twm_qtick.sv
`timescale 1ns/1ps
// Quarter-bit enable generator; the prescaler multiplies the period by four per step.
module twm_qtick (
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       run,
   input  wire logic [1:0] presc,
   output logic            tick
);
   logic [7:0] cnt_q;
   logic [7:0] lim;

   assign lim = (twm_pkg::QTR_CYCLES << {presc, 1'b0}) - 8'h01;

   // The counter restarts whenever the sequencer is not running a bus phase.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 8'h00;
         tick  <= 1'b0;
      end else if (!run) begin
         cnt_q <= 8'h00;
         tick  <= 1'b0;
      end else if (cnt_q >= lim) begin
         cnt_q <= 8'h00;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         tick  <= 1'b0;
      end
   end
endmodule // twm_qtick

// file: logic/twm_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for levels arriving from the bus pins.
module twm_sync #(
   parameter int W = 2
) (
   input  wire logic         mclk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // Pins idle high, so both stages reset to one.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '1;
         q      <= '1;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule // twm_sync

// file: logic/twm_top.sv
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Enabled control write with start request and flag clear issues START once bus free.
// - After START goes out, hardware sets the flag and posts status 0x08.
// - Direction bit of the address after START selects transmit or receive mode; here it only picks the read or write address codes.
// - While the flag is set the transfer is suspended until software clears it.
// - Status codes assume prescaler bits zero; software masks them before comparing.
// - After address with write and acknowledge, flag sets with 0x18, 0x20 or 0x38.
// - Data write while flag low is discarded and sets the write collision bit.
// - In 0x08, loaded address is sent after clearing flag with no start or stop.
// - In 0x10, a loaded address is sent; a read address switches to receive mode, but the code keeps transmitting the loaded byte.
// - In 0x18, a loaded data byte is sent and the slave acknowledge sampled.
// - Clearing the flag with start request only sends a repeated START.
// - Clearing with stop request only sends STOP, then hardware clears stop request.
// - Clearing with both requests sends STOP then START and clears stop request.
// - Byte load and flag clear repeat; transfer ends with STOP or repeated START.
// - After a repeated START the master keeps the bus for any slave or direction.
// - Read bit and not-acknowledge are high; write and acknowledge low; bytes are 8 bits.
// - The enable bit must be one; bus actions are ignored while disabled.
module twm_top (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   output logic             irq
);

   twm_pkg::twm_ctrl_t  ctrl_q;
   twm_pkg::twm_state_t state_q;
   logic [7:0]          data_q;
   logic [7:0]          shift_q;
   logic [7:0]          code_q;
   logic [1:0]          presc_q;
   logic [1:0]          phase_q;
   logic [3:0]          bit_q;
   logic                is_addr_q;
   logic                is_read_q;
   logic                nack_q;
   logic                session_q;
   logic                busy_q;
   logic                scl_prev_q;
   logic                sda_prev_q;
   logic                hw_set_q;
   logic                stop_done_q;
   logic [1:0]          pin_s;
   logic                scl_s;
   logic                sda_s;
   logic                tick;
   logic                adv;
   logic                run;
   logic                setup;
   logic                wr_acc;
   logic                wr_ctrl;
   logic                wr_data;
   logic                wr_stat;
   logic [7:0]          rd_mux;

   // Address decode, used for reads, writes and the error answer.
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   // Both bus pins come from outside the clock domain.
   twm_sync #(
      .W (2)
   ) u_sync (
      .mclk (mclk),
      .rstn (rstn),
      .d    ({scl_i, sda_i}),
      .q    (pin_s)
   );

   assign scl_s = pin_s[1];
   assign sda_s = pin_s[0];

   // The quarter-bit divider only runs while a bus phase is being driven.
   assign run = (state_q == twm_pkg::S_START) || (state_q == twm_pkg::S_XFER) ||
                (state_q == twm_pkg::S_STOP);

   twm_qtick u_tick (
      .mclk  (mclk),
      .rstn  (rstn),
      .run   (run),
      .presc (presc_q),
      .tick  (tick)
   );

   // Phase two waits for the released clock line to read high, which honours clock stretching.
   assign adv = tick && ((phase_q != 2'h2) || scl_s);

   // APB strobes; every access completes with one wait-free access cycle.
   assign setup   = psel && !penable;
   assign wr_acc  = psel && penable && pwrite && pready;
   assign wr_ctrl = wr_acc && hit(paddr, twm_pkg::CTRL_OFS);
   assign wr_data = wr_acc && hit(paddr, twm_pkg::DATA_OFS);
   assign wr_stat = wr_acc && hit(paddr, twm_pkg::STAT_OFS);

   // Read selection; the status register returns code and prescaler side by side.
   always_comb begin
      rd_mux = 8'h00;
      if (hit(paddr, twm_pkg::CTRL_OFS)) begin
         rd_mux = ctrl_q;
      end else if (hit(paddr, twm_pkg::DATA_OFS)) begin
         rd_mux = data_q;
      end else if (hit(paddr, twm_pkg::STAT_OFS)) begin
         rd_mux = (code_q & twm_pkg::STAT_CODE_MASK) | {6'h00, presc_q};
      end
   end

   // The answer is prepared in the setup cycle so that every APB output comes from a flop.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup && !(hit(paddr, twm_pkg::CTRL_OFS) || hit(paddr, twm_pkg::DATA_OFS) ||
                               hit(paddr, twm_pkg::STAT_OFS));
         if (setup) begin
            prdata <= {24'h00_0000, rd_mux};
         end
      end
   end

   // Interrupt flag: hardware set wins over a software clear in the same cycle.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q.flag <= 1'b0;
      end else if (hw_set_q) begin
         ctrl_q.flag <= 1'b1;
      end else if (wr_ctrl && pwdata[7]) begin
         ctrl_q.flag <= 1'b0;
      end
   end

   // Plain control fields written by software.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q.ack_enable    <= twm_pkg::CTRL_RST[6];
         ctrl_q.start_req_bit <= twm_pkg::CTRL_RST[5];
         ctrl_q.enable        <= twm_pkg::CTRL_RST[2];
         ctrl_q.rsvd          <= twm_pkg::CTRL_RST[1];
         ctrl_q.irq_enable    <= twm_pkg::CTRL_RST[0];
      end else if (wr_ctrl) begin
         ctrl_q.ack_enable    <= pwdata[6];
         ctrl_q.start_req_bit <= pwdata[5];
         ctrl_q.enable        <= pwdata[2];
         ctrl_q.rsvd          <= 1'b0;
         ctrl_q.irq_enable    <= pwdata[0];
      end
   end

   // The stop request clears itself once the STOP condition is on the bus.
   // A software write in the same cycle is kept, as it carries the newer intent.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q.stop_req_bit <= twm_pkg::CTRL_RST[4];
      end else if (wr_ctrl) begin
         ctrl_q.stop_req_bit <= pwdata[4];
      end else if (stop_done_q) begin
         ctrl_q.stop_req_bit <= 1'b0;
      end
   end

   // Data register and write collision; a late write never reaches the shifter.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         data_q                 <= twm_pkg::DATA_RST;
         ctrl_q.write_collision <= twm_pkg::CTRL_RST[3];
      end else if (wr_data) begin
         if (ctrl_q.flag) begin
            data_q                 <= pwdata[7:0];
            ctrl_q.write_collision <= 1'b0;
         end else begin
            ctrl_q.write_collision <= 1'b1;
         end
      end
   end

   // Prescaler bits are the only writable part of the status register.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         presc_q <= twm_pkg::PRESC_RST;
      end else if (wr_stat) begin
         presc_q <= pwdata[1:0];
      end
   end

   // Bus-free tracking from START and STOP seen on the synchronised lines.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         busy_q     <= 1'b0;
      end else begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
         if (scl_s && scl_prev_q && sda_prev_q && !sda_s) begin
            busy_q <= 1'b1;
         end else if (scl_s && scl_prev_q && !sda_prev_q && sda_s) begin
            busy_q <= 1'b0;
         end
      end
   end

   // Interrupt request follows the flag gated by its enable.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= ctrl_q.flag && ctrl_q.irq_enable;
      end
   end

   // Open-drain pins only ever pull low, so the driven level is a constant zero.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end else begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end
   end

   // Bus sequencer. Each bus phase ends on a quarter tick; the clock line is held low
   // in the hold state, which is what suspends the slave while software decides.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q     <= twm_pkg::S_IDLE;
         phase_q     <= 2'h0;
         bit_q       <= 4'h0;
         shift_q     <= 8'h00;
         is_addr_q   <= 1'b0;
         is_read_q   <= 1'b0;
         nack_q      <= 1'b0;
         session_q   <= 1'b0;
         code_q      <= twm_pkg::ST_NO_INFO;
         scl_oe      <= 1'b0;
         sda_oe      <= 1'b0;
         hw_set_q    <= 1'b0;
         stop_done_q <= 1'b0;
      end else begin
         hw_set_q    <= 1'b0;
         stop_done_q <= 1'b0;
         if (!ctrl_q.enable) begin
            // Disabled: release both lines and drop any transfer in flight.
            state_q   <= twm_pkg::S_IDLE;
            phase_q   <= 2'h0;
            session_q <= 1'b0;
            scl_oe    <= 1'b0;
            sda_oe    <= 1'b0;
         end else begin
            case (state_q)
               twm_pkg::S_IDLE: begin
                  // A flag still being set by hardware counts as set, so no START slips out after a loss.
                  if (ctrl_q.start_req_bit && !ctrl_q.flag && !hw_set_q) begin
                     state_q <= twm_pkg::S_FREE;
                  end
               end
               twm_pkg::S_FREE: begin
                  if (!busy_q) begin
                     state_q <= twm_pkg::S_START;
                     phase_q <= 2'h0;
                  end
               end
               twm_pkg::S_START: begin
                  // Release data, release clock, pull data low while clock high, pull clock.
                  if (adv) begin
                     phase_q <= phase_q + 2'h1;
                     case (phase_q)
                        2'h0: sda_oe <= 1'b0;
                        2'h1: scl_oe <= 1'b0;
                        2'h2: sda_oe <= 1'b1;
                        default: begin
                           scl_oe    <= 1'b1;
                           state_q   <= twm_pkg::S_HOLD;
                           hw_set_q  <= 1'b1;
                           session_q <= 1'b1;
                           code_q    <= session_q ? twm_pkg::ST_REP_START : twm_pkg::ST_START;
                        end
                     endcase
                  end
               end
               twm_pkg::S_XFER: begin
                  if (adv) begin
                     phase_q <= phase_q + 2'h1;
                     case (phase_q)
                        2'h0: begin
                           // A one is sent by releasing the line; the acknowledge slot is released.
                           sda_oe <= (bit_q == twm_pkg::ACK_BIT_IDX) ? 1'b0 : !shift_q[7];
                        end
                        2'h1: scl_oe <= 1'b0;
                        2'h2: begin
                           if (bit_q == twm_pkg::ACK_BIT_IDX) begin
                              nack_q <= sda_s;
                           end else if (shift_q[7] && !sda_s) begin
                              // Another master pulled a released line low: give up the bus.
                              state_q   <= twm_pkg::S_IDLE;
                              scl_oe    <= 1'b0;
                              sda_oe    <= 1'b0;
                              session_q <= 1'b0;
                              hw_set_q  <= 1'b1;
                              code_q    <= twm_pkg::ST_ARB_LOST;
                           end else begin
                              shift_q <= {shift_q[6:0], 1'b0};
                           end
                        end
                        default: begin
                           scl_oe <= 1'b1;
                           if (bit_q == twm_pkg::ACK_BIT_IDX) begin
                              state_q  <= twm_pkg::S_HOLD;
                              hw_set_q <= 1'b1;
                              if (!is_addr_q) begin
                                 code_q <= nack_q ? twm_pkg::ST_D_NACK : twm_pkg::ST_D_ACK;
                              end else if (is_read_q) begin
                                 code_q <= nack_q ? twm_pkg::ST_AR_NACK : twm_pkg::ST_AR_ACK;
                              end else begin
                                 code_q <= nack_q ? twm_pkg::ST_AW_NACK : twm_pkg::ST_AW_ACK;
                              end
                           end else begin
                              bit_q <= bit_q + 4'h1;
                           end
                        end
                     endcase
                  end
               end
               twm_pkg::S_HOLD: begin
                  // Nothing moves on the bus until software clears the flag; the set pulse is still in flight
                  // in the first hold cycle, so it is waited for as well.
                  if (!ctrl_q.flag && !hw_set_q) begin
                     phase_q <= 2'h0;
                     if (ctrl_q.stop_req_bit) begin
                        state_q <= twm_pkg::S_STOP;
                     end else if (ctrl_q.start_req_bit) begin
                        state_q <= twm_pkg::S_START;
                     end else begin
                        // After a START the loaded byte is an address; its low bit is the direction.
                        state_q   <= twm_pkg::S_XFER;
                        bit_q     <= 4'h0;
                        shift_q   <= data_q;
                        is_addr_q <= (code_q == twm_pkg::ST_START) || (code_q == twm_pkg::ST_REP_START);
                        if ((code_q == twm_pkg::ST_START) || (code_q == twm_pkg::ST_REP_START)) begin
                           is_read_q <= data_q[0];
                        end
                     end
                  end
               end
               twm_pkg::S_STOP: begin
                  // Pull data low, release clock, release data while clock high.
                  if (adv) begin
                     phase_q <= phase_q + 2'h1;
                     case (phase_q)
                        2'h0: sda_oe <= 1'b1;
                        2'h1: scl_oe <= 1'b0;
                        2'h2: sda_oe <= 1'b0;
                        default: begin
                           stop_done_q <= 1'b1;
                           session_q   <= 1'b0;
                           code_q      <= twm_pkg::ST_NO_INFO;
                           // A pending start request follows the STOP at once.
                           state_q     <= ctrl_q.start_req_bit ? twm_pkg::S_FREE : twm_pkg::S_IDLE;
                        end
                     endcase
                  end
               end
               default: begin
                  state_q <= twm_pkg::S_IDLE;
                  scl_oe  <= 1'b0;
                  sda_oe  <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule // twm_top
